/* File: seq_pkg.sv */
// Constants and carrier types shared by the filter sequencer files
`default_nettype none
package seq_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CNT_W = 14;
  localparam int unsigned CONV_W = 6;
  localparam int unsigned CNT_TOP = CNT_W - 1;
  localparam int unsigned DECIM_CYCLES = 64;
  localparam int unsigned SETTLE_CYCLES = 8192;
  localparam int unsigned FILTER_SETTLE_CYCLES = 5376;
  localparam int unsigned GROUP_DELAY_CYCLES = 2688;

  // ------------------------------------------------------------
  // Counter values
  // ------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RESET = 14'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;
  localparam logic [CONV_W-1:0] CONV_LAST = 6'h3F;

  // ------------------------------------------------------------
  // Pin group carried through the synchroniser
  // ------------------------------------------------------------
  typedef struct packed {
    logic sync;
    logic reset;
    logic cal;
    logic frame_sync;
    logic serial_mode;
  } pins_t;

  localparam int unsigned PINS_W = $bits(pins_t);
  localparam logic [PINS_W-1:0] PINS_RESET = 5'h00;

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_SETTLE,
    ST_LOAD,
    ST_RUN
  } seq_state_t;

  // ------------------------------------------------------------
  // Registered output group
  // ------------------------------------------------------------
  typedef struct packed {
    logic result_valid;
    logic result_ready_n;
    logic update;
    logic filter_reset;
    logic modulator_reset;
    logic cal_clear;
  } status_t;

  localparam logic [5:0] STATUS_RESET = 6'h10;

endpackage : seq_pkg
`default_nettype wire

/* File: pin_sync.sv */
// Two-flop synchroniser for the sequencer's asynchronous pin group
`default_nettype none
module pin_sync (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire seq_pkg::pins_t pins_i,
  output seq_pkg::pins_t pins_o
);

  // ------------------------------------------------------------
  // Synchroniser stages
  // ------------------------------------------------------------
  // First stage is read only by the second stage
  logic [seq_pkg::PINS_W-1:0] meta_r;
  logic [seq_pkg::PINS_W-1:0] stable_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= seq_pkg::PINS_RESET;
      stable_r <= seq_pkg::PINS_RESET;
    end else begin
      meta_r <= pins_i;
      stable_r <= meta_r;
    end
  end

  assign pins_o = stable_r;

endmodule : pin_sync
`default_nettype wire

/* File: filter_sequencer_sync_control.sv */
// Filter sequencer: cycle counter, decimation pacing and sync/settle control
`default_nettype none
module filter_sequencer_sync_control (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic SYNC_I,
  input wire logic RESET_I,
  input wire logic CAL_I,
  input wire logic FRAME_SYNC_INPUT_I,
  input wire logic SERIAL_MODE_I,
  output logic SERIAL_RESULT_VALID_O,
  output logic PARALLEL_RESULT_READY_N_O,
  output logic OUTPUT_UPDATE_O,
  output logic FILTER_RESET_O,
  output logic MODULATOR_RESET_O,
  output logic CAL_REGS_CLEAR_O,
  output logic [seq_pkg::CNT_W-1:0] CYCLE_COUNT_O
);

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  seq_pkg::pins_t pins_raw;
  seq_pkg::pins_t pins_s;

  assign pins_raw.sync = SYNC_I;
  assign pins_raw.reset = RESET_I;
  assign pins_raw.cal = CAL_I;
  assign pins_raw.frame_sync = FRAME_SYNC_INPUT_I;
  assign pins_raw.serial_mode = SERIAL_MODE_I;

  // Two clocks of latency apply equally to every device on a shared sync
  pin_sync u_pin_sync (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .pins_i(pins_raw),
    .pins_o(pins_s)
  );

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [seq_pkg::CNT_W-1:0] count_r;
  logic [seq_pkg::CNT_W-1:0] count_nxt;
  seq_pkg::seq_state_t state_r;
  seq_pkg::seq_state_t state_nxt;
  seq_pkg::status_t status_r;
  seq_pkg::status_t status_nxt;
  logic hold_prev_r;
  logic fsi_prev_r;
  logic cal_prev_r;
  logic fsi_seen_r;
  logic fsi_seen_nxt;
  logic cal_pend_r;
  logic cal_pend_nxt;
  logic settled_r;
  logic settled_nxt;

  // ------------------------------------------------------------
  // Event decode
  // ------------------------------------------------------------
  wire hold_req;
  wire hold_rise;
  wire fsi_rise;
  wire first_fsi;
  wire cal_rise;
  wire conv_end;
  wire cal_go;
  wire restart;
  wire running;
  wire top_reached;
  wire [seq_pkg::CNT_W-1:0] count_inc;

  // Reset pin holds the count and state exactly like sync, and alone drives modulator reset and cal clear
  assign hold_req = pins_s.sync | pins_s.reset;
  assign hold_rise = hold_req & ~hold_prev_r;
  assign fsi_rise = pins_s.frame_sync & ~fsi_prev_r;
  assign first_fsi = fsi_rise & ~fsi_seen_r;
  assign cal_rise = pins_s.cal & ~cal_prev_r;
  assign conv_end = (count_r[seq_pkg::CONV_W-1:0] == seq_pkg::CONV_LAST);
  assign running = (state_r != seq_pkg::ST_HOLD);

  // Calibration waits for the running conversion to finish
  assign cal_go = cal_pend_r & conv_end & running & ~hold_req;
  assign restart = cal_go | first_fsi;

  // One count per clock, no prescaler, so all rates track the clock
  assign count_inc = count_r + seq_pkg::CNT_ONE;
  assign top_reached = count_nxt[seq_pkg::CNT_TOP];

  // ------------------------------------------------------------
  // Cycle counter next value
  // ------------------------------------------------------------
  always_comb begin
    // Rising edge and held level both pin the count at zero
    if (hold_rise) begin
      count_nxt = seq_pkg::CNT_RESET;
    end else if (hold_req) begin
      count_nxt = seq_pkg::CNT_RESET;
    end else if (restart) begin
      count_nxt = seq_pkg::CNT_RESET;
    end else begin
      count_nxt = count_inc;
    end
  end

  // ------------------------------------------------------------
  // Sequencer state
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (hold_req) begin
      state_nxt = seq_pkg::ST_HOLD;
    end else if (restart) begin
      state_nxt = seq_pkg::ST_SETTLE;
    end else begin
      unique case (state_r)
        seq_pkg::ST_HOLD: begin
          // Sync sampled low: filter leaves reset and starts gathering
          state_nxt = seq_pkg::ST_SETTLE;
        end
        seq_pkg::ST_SETTLE: begin
          // Fixed window is longer than true filter settling on purpose
          if (top_reached) begin
            state_nxt = seq_pkg::ST_LOAD;
          end
        end
        seq_pkg::ST_LOAD: begin
          if (conv_end) begin
            state_nxt = seq_pkg::ST_RUN;
          end
        end
        seq_pkg::ST_RUN: begin
          state_nxt = seq_pkg::ST_RUN;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pending calibration and first frame sync flags
  // ------------------------------------------------------------
  // A new request wins over the clear; sync or reset aborts calibration
  assign cal_pend_nxt = ~hold_req & (cal_rise | (cal_pend_r & ~cal_go));
  assign fsi_seen_nxt = fsi_seen_r | fsi_rise;

  // ------------------------------------------------------------
  // Filter settle guard
  // ------------------------------------------------------------
  wire [seq_pkg::CNT_W-1:0] settle_mark;
  wire settle_hit;

  // True settling is shorter than the top-bit window, so this never delays valid
  assign settle_mark = seq_pkg::FILTER_SETTLE_CYCLES[seq_pkg::CNT_W-1:0];
  assign settle_hit = (count_nxt == settle_mark);
  assign settled_nxt = (settled_r & ~hold_req & ~restart) | settle_hit;

  // ------------------------------------------------------------
  // Output next values
  // ------------------------------------------------------------
  wire valid_win;
  wire ready_win;
  wire valid_nxt;
  wire ready_n_nxt;
  wire update_nxt;
  wire filter_reset_nxt;
  wire modulator_reset_nxt;
  wire cal_clear_nxt;

  // Settle guard is redundant with the top bit, kept so a shorter window cannot leak data on serial valid; parallel ready is not gated by it
  assign valid_win = ((state_nxt == seq_pkg::ST_LOAD) | (state_nxt == seq_pkg::ST_RUN)) & settled_r;
  assign ready_win = (state_nxt == seq_pkg::ST_RUN);

  // Valid is low whenever the word may be stale or unsettled
  assign valid_nxt = pins_s.serial_mode & valid_win;
  // Ready idles high in serial mode since nobody reads it there
  assign ready_n_nxt = ~(~pins_s.serial_mode & ready_win);
  assign update_nxt = conv_end & running & ~hold_req & ~restart;
  assign filter_reset_nxt = hold_req;
  assign modulator_reset_nxt = pins_s.reset;
  // Sync alone never touches the calibration registers
  assign cal_clear_nxt = pins_s.reset;

  always_comb begin
    status_nxt.result_valid = valid_nxt;
    status_nxt.result_ready_n = ready_n_nxt;
    status_nxt.update = update_nxt;
    status_nxt.filter_reset = filter_reset_nxt;
    status_nxt.modulator_reset = modulator_reset_nxt;
    status_nxt.cal_clear = cal_clear_nxt;
  end

  // ------------------------------------------------------------
  // Flip-flops
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      count_r <= seq_pkg::CNT_RESET;
    end else begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_r <= seq_pkg::ST_SETTLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      status_r <= seq_pkg::STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Edge detectors reset to the idle low level so no false edge follows reset
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      hold_prev_r <= 1'b0;
    end else begin
      hold_prev_r <= hold_req;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      fsi_prev_r <= 1'b0;
    end else begin
      fsi_prev_r <= pins_s.frame_sync;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cal_prev_r <= 1'b0;
    end else begin
      cal_prev_r <= pins_s.cal;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      fsi_seen_r <= 1'b0;
    end else begin
      fsi_seen_r <= fsi_seen_nxt;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cal_pend_r <= 1'b0;
    end else begin
      cal_pend_r <= cal_pend_nxt;
    end
  end

  // Settle flag clears with any restart so a fresh window is always required
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      settled_r <= 1'b0;
    end else begin
      settled_r <= settled_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign SERIAL_RESULT_VALID_O = status_r.result_valid;
  assign PARALLEL_RESULT_READY_N_O = status_r.result_ready_n;
  assign OUTPUT_UPDATE_O = status_r.update;
  assign FILTER_RESET_O = status_r.filter_reset;
  assign MODULATOR_RESET_O = status_r.modulator_reset;
  assign CAL_REGS_CLEAR_O = status_r.cal_clear;
  assign CYCLE_COUNT_O = count_r;

endmodule : filter_sequencer_sync_control
`default_nettype wire

/* File: seq_chk.sv */
// Assertion checker bound to the filter sequencer ports
`default_nettype none
module seq_chk (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic SERIAL_RESULT_VALID_O,
  input wire logic PARALLEL_RESULT_READY_N_O,
  input wire logic OUTPUT_UPDATE_O,
  input wire logic FILTER_RESET_O,
  input wire logic MODULATOR_RESET_O,
  input wire logic CAL_REGS_CLEAR_O,
  input wire logic [seq_pkg::CNT_W-1:0] CYCLE_COUNT_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (!NRST_I);
  sequence release_s;
    CYCLE_COUNT_O == 14'h0001 ##1 CYCLE_COUNT_O == 14'h0002;
  endsequence
  hold_zero_a: assert property (FILTER_RESET_O |-> CYCLE_COUNT_O == 14'h0000)
    else $error("count not zero in hold");
  release_run_a: assert property ($fell(FILTER_RESET_O) |-> release_s)
    else $error("count did not start after release");
  update_phase_a: assert property (OUTPUT_UPDATE_O |-> CYCLE_COUNT_O[5:0] == 6'h00 && !FILTER_RESET_O)
    else $error("update off the decimation boundary");
  update_gap_a: assert property (OUTPUT_UPDATE_O |=> !OUTPUT_UPDATE_O [*8])
    else $error("updates too close");
  valid_top_a: assert property ($rose(SERIAL_RESULT_VALID_O) |-> CYCLE_COUNT_O == 14'h2000)
    else $error("valid rose off the top bit");
  ready_late_a: assert property ($fell(PARALLEL_RESULT_READY_N_O) |-> CYCLE_COUNT_O == 14'h2040)
    else $error("ready fell at wrong count");
  hold_quiet_a: assert property (FILTER_RESET_O |-> !SERIAL_RESULT_VALID_O && PARALLEL_RESULT_READY_N_O)
    else $error("result flagged during hold");
  cal_clear_a: assert property (CAL_REGS_CLEAR_O |-> MODULATOR_RESET_O && FILTER_RESET_O)
    else $error("clear without full reset");
  free_run_a: assert property (!FILTER_RESET_O |=> FILTER_RESET_O || CYCLE_COUNT_O == 14'h0000 ||
    CYCLE_COUNT_O == $past(CYCLE_COUNT_O) + 14'h0001)
    else $error("count skipped");
endmodule : seq_chk
bind filter_sequencer_sync_control seq_chk u_chk (.CLK_I(CLK_I), .NRST_I(NRST_I),
  .SERIAL_RESULT_VALID_O(SERIAL_RESULT_VALID_O), .PARALLEL_RESULT_READY_N_O(PARALLEL_RESULT_READY_N_O),
  .OUTPUT_UPDATE_O(OUTPUT_UPDATE_O), .FILTER_RESET_O(FILTER_RESET_O), .MODULATOR_RESET_O(MODULATOR_RESET_O),
  .CAL_REGS_CLEAR_O(CAL_REGS_CLEAR_O), .CYCLE_COUNT_O(CYCLE_COUNT_O));
`default_nettype wire

/* File: seq_host.sv */
// Controller model issuing one-cycle sync pulses
`default_nettype none
module seq_host (
  input wire logic clk_i,
  input wire logic go_i,
  output logic sync_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic go_r;
  always @(posedge clk_i) go_r <= go_i;
  // Falling-edge launch so the next rising edge samples it half a clock after it changes
  always @(negedge clk_i) sync_o <= go_r;
endmodule : seq_host
`default_nettype wire

/* File: filter_sequencer_sync_control_tb_top.sv */
// Self-checking bench for the filter sequencer
`default_nettype none
module filter_sequencer_sync_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic rst_p = 1'b0;
  logic cal = 1'b0;
  logic frame_sync_input = 1'b0;
  logic ser = 1'b1;
  logic sync_w, val, rdy_n, upd, frst, mrst, cclr;
  logic [seq_pkg::CNT_W-1:0] cnt;
  int err_count = 0;
  int checks = 0;
  always #10 clk = ~clk;
  seq_host host (.clk_i(clk), .go_i(go), .sync_o(sync_w));
  filter_sequencer_sync_control dut (.CLK_I(clk), .NRST_I(nrst), .SYNC_I(sync_w), .RESET_I(rst_p),
    .CAL_I(cal), .FRAME_SYNC_INPUT_I(frame_sync_input), .SERIAL_MODE_I(ser), .SERIAL_RESULT_VALID_O(val),
    .PARALLEL_RESULT_READY_N_O(rdy_n), .OUTPUT_UPDATE_O(upd), .FILTER_RESET_O(frst),
    .MODULATOR_RESET_O(mrst), .CAL_REGS_CLEAR_O(cclr), .CYCLE_COUNT_O(cnt));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Counts from a restart until the active mode flags a result
  task automatic span(output logic [15:0] n);
    n = 16'h0000;
    while (n < 16'h2400 && (ser ? val !== 1'b1 : rdy_n !== 1'b0)) begin
      cyc(1);
      n++;
    end
  endtask : span
  task automatic t_frame;
    logic [15:0] n;
    cyc(100);
    frame_sync_input = 1'b1;
    for (int i = 0; i < 10 && cnt !== 14'h0000; i++) cyc(1);
    chk("frame restart", cnt, 16'h0000);
    span(n);
    chk("frame settle", n, 16'h2000);
    chk("count at top", cnt, 16'h2000);
  endtask : t_frame
  task automatic t_update;
    logic [15:0] n;
    n = 16'h0000;
    for (int i = 0; i < 70 && upd !== 1'b1; i++) cyc(1);
    chk("update phase", cnt[5:0], 16'h0000);
    do begin
      cyc(1);
      n++;
    end while (upd !== 1'b1 && n < 16'h0080);
    chk("update spacing", n, 16'h0040);
    for (int i = 0; i < 17000 && cnt !== 14'h3FFF; i++) cyc(1);
    cyc(1);
    chk("count wrap", {frst, cnt}, 16'h0000);
  endtask : t_update
  task automatic t_sync;
    logic [15:0] n;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    for (int i = 0; i < 20 && frst !== 1'b1; i++) cyc(1);
    chk("hold count", {val, cnt}, 16'h0000);
    chk("cal kept", {mrst, cclr}, 16'h0000);
    span(n);
    chk("sync settle", n, 16'h2000);
  endtask : t_sync
  task automatic t_cal;
    logic [15:0] n;
    cal = 1'b1;
    cyc(2);
    cal = 1'b0;
    for (int i = 0; i < 80 && val !== 1'b0; i++) cyc(1);
    chk("cal restart", cnt, 16'h0000);
    span(n);
    chk("cal settle", n, 16'h2000);
  endtask : t_cal
  task automatic t_par;
    logic [15:0] n;
    ser = 1'b0;
    rst_p = 1'b1;
    cyc(3);
    chk("reset outputs", {frst, mrst, cclr, val}, 16'h000E);
    rst_p = 1'b0;
    for (int i = 0; i < 40 && frst !== 1'b0; i++) cyc(1);
    // Span starts one edge after the last held edge
    span(n);
    chk("parallel settle", n + 16'h0001, 16'h2040);
    chk("parallel count", cnt, 16'h2040);
    chk("serial flag idle", val, 16'h0000);
  endtask : t_par
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    cyc(5);
    nrst = 1'b1;
    t_frame();
    t_update();
    t_sync();
    t_cal();
    t_par();
    summarize();
  end
  // Run needs about 41k cycles; stop at 80k to stay well inside budget
  initial begin
    #1600000;
    err_count++;
    summarize();
  end
endmodule : filter_sequencer_sync_control_tb_top
`default_nettype wire
